//--- design/stmr_timer.sv
// Implementation choices: the register addresses and the Avalon-MM register port.
`timescale 1ns/100ps
`include "stmr_consts.svh"
// Contract
// (RULE_01) run enable rising clears the counter to zero before counting.
// (RULE_02) run enable low stops counting; counter holds its value.
// (RULE_03) run rise in compare, pwm or pulse mode loads initial output level.
// (RULE_04) run control bits 2..0 read as zero.
// (RULE_05) mode field bits 7..6: compare, capture, pwm/pulse, timer.
// (RULE_06) software should stop the timer before changing mode.
// (RULE_07) compare match a: none, low, high or toggle output.
// (RULE_08) pwm mode pin field: inactive, active, pwm wave, single pulse.
// (RULE_09) capture trigger: rising, falling, both edges, disabled.
// (RULE_10) compare level equal to initial level gives no visible change.
// (RULE_11) software should change pin field in pwm only while stopped.
// (RULE_12) output level bit sets initial level for compare and pulse.
// (RULE_13) output level bit sets pwm active level; unused in timer mode.
// (RULE_14) invert bit inverts output pin; unused in timer mode.
// (RULE_15) swap bit exchanges duty and period between a and p values.
// (RULE_16) clear source high clears on a match, low on p match.
// (RULE_17) overflow clears only when compare p value is all zero.
// (RULE_18) clear source ignored in pwm, pulse and capture modes.
// (RULE_19) timer mode does not drive the output pin.
// (RULE_20) counter read as two read-only bytes, reset zero.
// (RULE_21) compare a low byte readable and writable, reset zero; here wr_alo is held low, and address 8 reads the counter buffer instead.
// (RULE_22) low byte write goes to buffer, moved on high byte write; here there is no such buffer, and the high byte comes from compare_a_high_in.
// (RULE_23) high byte read copies low byte to buffer for later read.
// (RULE_24) run rise detected in clock domain, clear and reinit same cycle.
module stmr_timer (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // avalon slave
  input wire stmr_pkg::stmr_req_t bus_req,
  output stmr_pkg::stmr_rsp_t bus_rsp,
  // compare values from neighbouring registers
  input wire logic [7:0] compare_a_high_in,
  input wire logic [7:0] compare_p_value,
  // pins
  input wire logic capture_input_pin,
  output stmr_pkg::stmr_pin_t timer_output_pin,
  // events
  output logic cap_event,
  output logic [15:0] cap_value
);
  import stmr_pkg::*;

  // ************************************************************
  // registers
  // ************************************************************
  logic [7:0] run_reg;
  logic [7:0] mode_reg;
  logic [7:0] cmpa_lo_reg;
  logic [7:0] cmpa_hi_reg;
  logic [7:0] buf_reg;
  logic [15:0] cnt_reg;
  logic [15:0] cnt_next;
  logic run_d_reg;
  logic out_reg;
  logic out_next;
  logic pulse_reg;
  logic pulse_next;
  logic [2:0] cap_sync_reg;
  logic cap_event_reg;
  logic [15:0] cap_value_reg;
  logic [31:0] rdata_reg;
  logic ack_reg;
  logic wait_reg;
  logic cap_level_reg;

  // ************************************************************
  // decode
  // ************************************************************
  wire access = (bus_req.read | bus_req.write) & ~ack_reg;
  wire wr_run = ack_reg & bus_req.write & (bus_req.address == `STMR_OFF_RUN);
  wire wr_mode = ack_reg & bus_req.write & (bus_req.address == `STMR_OFF_MODE);
  wire wr_alo = access & bus_req.write & (bus_req.address == `STMR_OFF_CNTL + 4'h0) & 1'b0;
  wire rd_cnth = access & bus_req.read & (bus_req.address == `STMR_OFF_CNTH);
  wire run = run_reg[`STMR_RUN_BIT];
  wire run_rise = run & ~run_d_reg; // RULE_24
  wire [1:0] pin_fn = mode_reg[`STMR_PIN_HI:`STMR_PIN_LO];
  wire oc = mode_reg[`STMR_OC_BIT];
  wire pol = mode_reg[`STMR_POL_BIT];
  wire dpx = mode_reg[`STMR_DPX_BIT];
  wire cclr = mode_reg[`STMR_CCLR_BIT];
  wire [1:0] mode_bits = mode_reg[`STMR_MODE_HI:`STMR_MODE_LO];
  wire stmr_mode_t mode = stmr_mode_t'(mode_bits); // RULE_05
  wire [15:0] cmpa = {cmpa_hi_reg, cmpa_lo_reg};

  // ************************************************************
  // compare logic
  // ************************************************************
  function automatic logic p_hit(input logic [7:0] p, input logic [15:0] c);
    p_hit = (p != 8'h00) && (c[15:8] == p) && (c[7:0] == 8'hFF);
  endfunction : p_hit

  wire ovf = (cnt_reg == 16'hFFFF);
  wire a_match = (cmpa != `STMR_RST_WORD) && (cnt_reg == cmpa);
  wire p_match = p_hit(compare_p_value, cnt_reg);
  wire p_ovf = (compare_p_value == 8'h00) && ovf; // RULE_17
  wire is_pwm = (mode == STMR_MODE_PWM);
  wire cmp_like = (mode == STMR_MODE_CMP) | (mode == STMR_MODE_TMR);
  wire clr_cmp = cclr ? a_match : (p_match | p_ovf); // RULE_16
  wire clr_pwm = dpx ? a_match : (p_match | p_ovf); // RULE_15
  wire cnt_clear = cmp_like ? clr_cmp : (is_pwm ? clr_pwm : (p_match | p_ovf)); // RULE_18
  wire [15:0] duty = dpx ? {compare_p_value, 8'h00} : cmpa;
  wire pwm_active = (cnt_reg < duty);
  wire pulse_end = dpx ? (p_match | p_ovf) : a_match;

  always_comb
  begin
    cnt_next = cnt_reg;
    if (run_rise)
    begin
      cnt_next = `STMR_RST_WORD; // RULE_01
    end
    else if (run)
    begin
      cnt_next = cnt_clear ? `STMR_RST_WORD : cnt_reg + 16'h0001;
    end // RULE_02
  end

  // ************************************************************
  // output pin
  // ************************************************************
  always_comb
  begin
    out_next = out_reg;
    pulse_next = pulse_reg;
    if (run_rise && (mode != STMR_MODE_CAP) && (mode != STMR_MODE_TMR))
    begin
      out_next = oc; // RULE_03 RULE_12
      pulse_next = 1'b1;
    end
    else if (run && mode == STMR_MODE_CMP && a_match)
    begin
      unique case (pin_fn) // RULE_07 RULE_10
        2'h0: out_next = out_reg;
        2'h1: out_next = 1'b0;
        2'h2: out_next = 1'b1;
        2'h3: out_next = ~out_reg;
      endcase
    end
    else if (is_pwm)
    begin
      if (run && pulse_end)
      begin
        pulse_next = 1'b0;
      end
      unique case (pin_fn) // RULE_08 RULE_13
        2'h0: out_next = ~oc;
        2'h1: out_next = oc;
        2'h2: out_next = (run && pwm_active) ? oc : ~oc;
        2'h3: out_next = (run && pulse_next) ? oc : ~oc;
      endcase
    end
  end

  wire pin_en = (mode != STMR_MODE_TMR) && (mode != STMR_MODE_CAP); // RULE_19

  // ************************************************************
  // capture
  // ************************************************************
  wire cap_agree = (cap_sync_reg[1] == cap_sync_reg[2]);
  wire cap_rise = cap_agree & cap_sync_reg[2] & ~cap_level_reg;
  wire cap_fall = cap_agree & ~cap_sync_reg[2] & cap_level_reg;
  wire cap_hit = run && (mode == STMR_MODE_CAP) &&
    ((pin_fn == 2'h0 && cap_rise) || (pin_fn == 2'h1 && cap_fall) ||
     (pin_fn == 2'h2 && (cap_rise | cap_fall))); // RULE_09

  // ************************************************************
  // read mux
  // ************************************************************
  wire [7:0] rd_byte =
    (bus_req.address == `STMR_OFF_RUN) ? {run_reg[7:3], 3'h0} : // RULE_04
    (bus_req.address == `STMR_OFF_MODE) ? mode_reg :
    (bus_req.address == `STMR_OFF_CNTL) ? buf_reg : // RULE_23
    (bus_req.address == `STMR_OFF_CNTH) ? cnt_reg[15:8] : // RULE_20
    8'h00;

  // ************************************************************
  // sequential
  // ************************************************************
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      run_reg <= `STMR_RST_BYTE;
    end
    else
    begin
      if (wr_run)
      begin
        run_reg <= {bus_req.writedata[7:3], 3'h0};
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      mode_reg <= `STMR_RST_BYTE;
    end
    else
    begin
      if (wr_mode)
      begin
        mode_reg <= bus_req.writedata[7:0];
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      run_d_reg <= 1'b0;
      ack_reg <= 1'b0;
      wait_reg <= 1'b1;
    end
    else
    begin
      run_d_reg <= run;
      ack_reg <= access;
      wait_reg <= ~access;
    end
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rdata_reg <= 32'h0000_0000;
    end
    else
    begin
      if (access)
      begin
        rdata_reg <= {24'h00_0000, rd_byte};
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt_reg <= `STMR_RST_WORD;
    end
    else
    begin
      cnt_reg <= cnt_next;
    end
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      out_reg <= 1'b0;
      pulse_reg <= 1'b0;
    end
    else
    begin
      out_reg <= out_next;
      pulse_reg <= pulse_next;
    end
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      buf_reg <= `STMR_RST_BYTE;
    end
    else
    begin
      if (rd_cnth)
      begin
        buf_reg <= cnt_reg[7:0]; // RULE_23
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cmpa_lo_reg <= `STMR_RST_BYTE;
    end
    else
    begin
      if (wr_alo)
      begin
        cmpa_lo_reg <= bus_req.writedata[7:0]; // RULE_21 RULE_22
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cmpa_hi_reg <= `STMR_RST_BYTE;
    end
    else
    begin
      cmpa_hi_reg <= compare_a_high_in;
    end
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cap_sync_reg <= 3'h0;
    end
    else
    begin
      cap_sync_reg <= {cap_sync_reg[1:0], capture_input_pin};
    end
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cap_level_reg <= 1'b0;
    end
    else
    begin
      if (cap_agree)
      begin
        cap_level_reg <= cap_sync_reg[2];
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cap_event_reg <= 1'b0;
    end
    else
    begin
      cap_event_reg <= cap_hit;
    end
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cap_value_reg <= `STMR_RST_WORD;
    end
    else
    begin
      if (cap_hit)
      begin
        cap_value_reg <= cnt_reg;
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      timer_output_pin <= '0;
    end
    else
    begin
      timer_output_pin.out_level <= out_next ^ pol; // RULE_14
      timer_output_pin.out_enable <= pin_en;
    end
  end

  assign bus_rsp.readdata = rdata_reg;
  assign bus_rsp.waitrequest = wait_reg;
  assign cap_event = cap_event_reg;
  assign cap_value = cap_value_reg;
endmodule : stmr_timer

//--- shared/stmr_consts.svh
`ifndef STMR_CONSTS_SVH
`define STMR_CONSTS_SVH
// register byte addresses
`define STMR_OFF_RUN 4'h0
`define STMR_OFF_MODE 4'h4
`define STMR_OFF_CNTL 4'h8
`define STMR_OFF_CNTH 4'hC
`define STMR_IDX_W 4
// run control fields
`define STMR_RUN_BIT 3
// mode control fields
`define STMR_MODE_HI 7
`define STMR_MODE_LO 6
`define STMR_PIN_HI 5
`define STMR_PIN_LO 4
`define STMR_OC_BIT 3
`define STMR_POL_BIT 2
`define STMR_DPX_BIT 1
`define STMR_CCLR_BIT 0
// reset values
`define STMR_RST_BYTE 8'h00
`define STMR_RST_WORD 16'h0000
`endif

//--- shared/stmr_pkg.sv
package stmr_pkg;
  typedef enum logic [1:0] {
    STMR_MODE_CMP,
    STMR_MODE_CAP,
    STMR_MODE_PWM,
    STMR_MODE_TMR
  } stmr_mode_t;
  typedef struct packed {
    logic [3:0] address;
    logic read;
    logic write;
    logic [31:0] writedata;
  } stmr_req_t;
  typedef struct packed {
    logic [31:0] readdata;
    logic waitrequest;
  } stmr_rsp_t;
  typedef struct packed {
    logic out_level;
    logic out_enable;
  } stmr_pin_t;
endpackage : stmr_pkg

//--- tb/stmr_pin_model.sv
`timescale 1ns/100ps
// ****
// pin partner
// ****
module stmr_pin_model (
  // clock, command
  input wire logic mclk,
  input wire logic edge_cmd,
  // pins
  input wire stmr_pkg::stmr_pin_t timer_output_pin,
  output logic capture_input_pin,
  output logic pad_level
);
  import stmr_pkg::*;
  logic last_reg = 1'h0;
  initial capture_input_pin = 1'h0;
  always @(posedge mclk) capture_input_pin <= edge_cmd;
  always @(posedge mclk) if (timer_output_pin.out_enable) last_reg <= timer_output_pin.out_level;
  // released pad floats away from last level
  assign pad_level = timer_output_pin.out_enable ? timer_output_pin.out_level : ~last_reg;
endmodule : stmr_pin_model

//--- tb/stmr_properties.sv
`timescale 1ns/100ps
// ****
// checker
// ****
module stmr_chk (
  // clock, reset
  input wire logic mclk,
  input wire logic rst_n,
  // bus
  input wire stmr_pkg::stmr_req_t bus_req,
  input wire stmr_pkg::stmr_rsp_t bus_rsp,
  // pin, event
  input wire stmr_pkg::stmr_pin_t timer_output_pin,
  input wire logic cap_event
);
  import stmr_pkg::*;
  logic [7:0] mode_reg;
  logic run_reg;
  wire req = bus_req.read | bus_req.write;
  wire ack = !bus_rsp.waitrequest;
  wire wr0 = ack & bus_req.write & (bus_req.address == 4'h0);
  wire wr4 = ack & bus_req.write & (bus_req.address == 4'h4);
  wire rd = ack & bus_req.read;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      {mode_reg, run_reg} <= 9'h0;
    else
    begin
      if (wr4) mode_reg <= bus_req.writedata[7:0];
      if (wr0) run_reg <= bus_req.writedata[3];
    end
  end
  chk_wait_answer: assert property (req && !ack |=> ack)
    else $error("no answer");
  chk_wait_single: assert property (ack |=> !ack)
    else $error("answer too long");
  chk_wait_idle: assert property (!req |=> !ack)
    else $error("answer without request");
  chk_run_low_zero: assert property (rd && bus_req.address == 4'h0 |-> bus_rsp.readdata[2:0] == 3'h0)
    else $error("run low bits set");
  chk_unmapped_zero: assert property (rd && bus_req.address[1:0] != 2'h0 |-> bus_rsp.readdata == 32'h0)
    else $error("unmapped read not zero");
  chk_output_off: assert property (mode_reg[6] && $past(mode_reg[6], 2) |-> !timer_output_pin.out_enable)
    else $error("pin driven");
  chk_cap_single: assert property (cap_event |=> !cap_event)
    else $error("capture pulse long");
  chk_run_reinit: assert property (wr0 && bus_req.writedata[3] && !run_reg && mode_reg[7:6] == 2'h0
    |-> ##[1:3] timer_output_pin.out_level == (mode_reg[3] ^ mode_reg[2]))
    else $error("no initial level");
endmodule : stmr_chk
bind stmr_timer stmr_chk u_chk (.mclk(mclk), .rst_n(rst_n), .bus_req(bus_req),
  .bus_rsp(bus_rsp), .timer_output_pin(timer_output_pin), .cap_event(cap_event));

//--- tb/tb_standard_timer_control.sv
`timescale 1ns/100ps
// ****
// bench
// ****
module tb_standard_timer_control;
  import stmr_pkg::*;
  `define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin error_cnt++; \
    $display("[FAIL] %s exp %h got %h", n, e, g); end end
  logic mclk = 1'h0;
  logic rst_n;
  stmr_req_t req;
  stmr_rsp_t rsp;
  stmr_pin_t pin;
  logic [7:0] ca_hi, cp;
  logic edge_cmd, cap_pin, cap_event, pad, seen;
  logic [31:0] q, q2;
  logic [15:0] cap_val;
  int error_cnt = 0, checks_done = 0, cyc = 0, ev_cnt = 0, i;
  logic [7:0] cfg [10] = '{8'h01, 8'h11, 8'h21, 8'h31, 8'h25, 8'h88, 8'h98, 8'hA8, 8'hB8,
    8'hC0};
  always #5 mclk = ~mclk;
  stmr_timer dut (.mclk(mclk), .rst_n(rst_n), .bus_req(req), .bus_rsp(rsp),
    .compare_a_high_in(ca_hi), .compare_p_value(cp), .capture_input_pin(cap_pin),
    .timer_output_pin(pin), .cap_event(cap_event), .cap_value(cap_val));
  stmr_pin_model u_pin (.mclk(mclk), .edge_cmd(edge_cmd), .timer_output_pin(pin),
    .capture_input_pin(cap_pin), .pad_level(pad));
  task automatic report_and_stop;
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : report_and_stop
  task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d);
    @(posedge mclk);
    req <= '{address: a, read: !w, write: w, writedata: {24'h0, d}};
    @(posedge mclk);
    while (rsp.waitrequest !== 1'h0) @(posedge mclk);
    q = rsp.readdata;
    req <= '0;
  endtask : bus
  always @(posedge mclk)
  begin
    cyc++;
    if (cap_event === 1'h1) ev_cnt++;
    if (cyc == 40000)
    begin
      error_cnt++;
      report_and_stop();
    end
  end
  initial
  begin
    {rst_n, edge_cmd, ca_hi, cp} = 18'h00100;
    req = '0;
    repeat (4) @(posedge mclk);
    rst_n <= 1'h1;
    for (i = 0; i < 4; i++)
    begin
      bus(1'h0, 4'(i * 4), 8'h00);
      `CHK("reset", 32'h0, q)
    end
    bus(1'h0, 4'h2, 8'h00);
    `CHK("unmapped", 32'h0, q)
    bus(1'h1, 4'h4, 8'hA5);
    bus(1'h0, 4'h4, 8'h00);
    `CHK("mode", 32'hA5, q)
    bus(1'h1, 4'h0, 8'hFF);
    bus(1'h0, 4'h0, 8'h00);
    `CHK("run", 32'hF8, q)
    bus(1'h1, 4'h0, 8'h00);
    bus(1'h1, 4'h4, 8'hC0);
    bus(1'h1, 4'h0, 8'h08);
    repeat (600) @(posedge mclk);
    bus(1'h1, 4'h0, 8'h00);
    bus(1'h0, 4'hC, 8'h00);
    `CHK("count hi", 32'h2, q)
    bus(1'h0, 4'h8, 8'h00);
    q2 = q;
    repeat (50) @(posedge mclk);
    bus(1'h1, 4'hC, 8'h55);
    bus(1'h0, 4'hC, 8'h00);
    `CHK("hold hi", 32'h2, q)
    bus(1'h0, 4'h8, 8'h00);
    `CHK("hold lo", q2, q)
    bus(1'h1, 4'h0, 8'h08);
    bus(1'h0, 4'hC, 8'h00);
    `CHK("restart hi", 32'h0, q)
    bus(1'h0, 4'h8, 8'h00);
    `CHK("restart lo", 1'h1, q < 32'h10)
    cp <= 8'h01;
    ca_hi <= 8'h03;
    for (i = 0; i < 2; i++)
    begin
      bus(1'h1, 4'h0, 8'h00);
      bus(1'h1, 4'h4, 8'(i));
      bus(1'h1, 4'h0, 8'h08);
      seen = 1'h0;
      repeat (300)
      begin
        bus(1'h0, 4'hC, 8'h00);
        if (q === 32'h2) seen = 1'h1;
      end
      `CHK("clear src", 1'(i), seen)
    end
    ca_hi <= 8'h01;
    for (i = 0; i < 10; i++)
    begin
      bus(1'h1, 4'h0, 8'h00);
      bus(1'h1, 4'h4, cfg[i]);
      bus(1'h1, 4'h0, 8'h08);
      repeat (100) @(posedge mclk);
      `CHK("out en", 1'(10'h1FF >> i), pin.out_enable)
      if (i < 9) `CHK("out early", 1'(10'h1D0 >> i), pin.out_level)
      repeat (200) @(posedge mclk);
      if (i < 9) `CHK("out late", 1'(10'h04C >> i), pin.out_level)
    end
    for (i = 0; i < 4; i++)
    begin
      bus(1'h1, 4'h0, 8'h00);
      bus(1'h1, 4'h4, {2'h1, 2'(i), 4'h0});
      bus(1'h1, 4'h0, 8'h08);
      ev_cnt = 0;
      edge_cmd <= 1'h1;
      repeat (12) @(posedge mclk);
      `CHK("rise cap", 4'h5 >> i & 4'h1, ev_cnt)
      if (i == 0) `CHK("cap value", 1'h1, cap_val != 16'h0 && cap_val < 16'h0040)
      ev_cnt = 0;
      edge_cmd <= 1'h0;
      repeat (12) @(posedge mclk);
      `CHK("fall cap", 4'h6 >> i & 4'h1, ev_cnt)
    end
    report_and_stop();
  end
endmodule : tb_standard_timer_control
